// *** hdl/pdmev_regs.sv ***
// pdm event flags, publish configuration and interrupt enables behind an apb slave
// Notes on behaviour
// - the stopped flag sets when a transfer finishes, reads 0 otherwise, and a written 0 clears it.
// - the end flag sets once the last sample of the programmed count is stored in data ram.
// - after a stop, the end flag sets when the last sample taken after that stop is stored.
// - the started publish register picks the channel on which the started event is broadcast.
// - the stopped publish register picks the channel on which the stopped event is broadcast.
// - the end publish register holds a channel index and enable bit, resets to zero, and publishes only when enabled.
// - bit 0 of the enable register lets the started event interrupt.
// - bit 1 of the enable register lets the stopped event interrupt.
// - bit 2 of the enable register lets the end event interrupt, and all enables reset to zero.
// - writing 1 to a bit of the set-enable register turns that enable on, and reads return the enables.
// - writing 1 to the start trigger begins continuous sampling.
// - writing 1 to the stop trigger halts sampling, later giving the stopped and end events.
// - the started flag sets when a transfer has begun and reads 0 otherwise.
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module pdmev_regs
   import pdmev_pkg::*;
#(
   parameter int NUM_CHANNELS = 16
) (
   // clock and reset
   input  wire logic                    ref_clk,
   input  wire logic                    rst_n,
   // apb slave
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   output logic [31:0]                  prdata,
   output logic                         pready,
   output logic                         pslverr,
   // sampling and dma core
   output logic                         core_start,
   output logic                         core_stop,
   input  wire logic                    core_started,
   input  wire logic                    core_last_sample_stored,
   input  wire logic                    core_stopped,
   // interconnect and interrupt
   output logic [NUM_CHANNELS-1:0]      publish_started,
   output logic [NUM_CHANNELS-1:0]      stopped_publish_cfg,
   output logic [NUM_CHANNELS-1:0]      publish_end,
   output logic                         irq
);
   initial begin
      if (NUM_CHANNELS < 1 || NUM_CHANNELS > (1 << PDMEV_CHANNEL_INDEX_W)) begin
         $error("pdmev_regs: NUM_CHANNELS out of range");
      end
   end

   typedef struct packed {
      logic                        started_flag;
      logic                        stopped_flag;
      logic                        end_flag;
      logic [PDMEV_CHANNEL_INDEX_W-1:0]    pub_started_idx;
      logic                        pub_started_en;
      logic [PDMEV_CHANNEL_INDEX_W-1:0]    pub_stopped_idx;
      logic                        pub_stopped_en;
      logic [PDMEV_CHANNEL_INDEX_W-1:0]    pub_end_idx;
      logic                        pub_end_en;
      logic [PDMEV_NUM_EVENTS-1:0] irq_en;
      pdmev_state_t                state;
      logic                        start_pulse;
      logic                        stop_pulse;
      logic                        ack;
      logic                        err;
      logic [31:0]                 rdata;
      logic                        irq;
   } pdmev_regs_t;

   pdmev_regs_t s_q;
   pdmev_regs_t s_d;

   logic setup_phase;
   logic access_end;
   logic wr;
   logic rd;
   logic mapped;
   logic [31:0] rd_mux;

   // zero-wait-state slave: pready is registered from the setup cycle; a write commits only
   // at the access edge that sees pready, while read data is captured at setup so it stands then
   assign setup_phase = psel && !penable;
   assign access_end  = psel && penable && s_q.ack;
   assign wr          = access_end && pwrite;
   assign rd          = setup_phase && !pwrite;

   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         PDMEV_START_TRIGGER_OFF:  rd_mux = 32'h0000_0000;
         PDMEV_STOP_TRIGGER_OFF:   rd_mux = 32'h0000_0000;
         PDMEV_STARTED_FLAG_OFF:   rd_mux = {31'h0, s_q.started_flag};
         PDMEV_STOPPED_FLAG_OFF:   rd_mux = {31'h0, s_q.stopped_flag};
         PDMEV_END_FLAG_OFF:       rd_mux = {31'h0, s_q.end_flag};
         PDMEV_PUB_STARTED_OFF:    rd_mux = {s_q.pub_started_en, 27'h0, s_q.pub_started_idx};
         PDMEV_PUB_STOPPED_OFF:    rd_mux = {s_q.pub_stopped_en, 27'h0, s_q.pub_stopped_idx};
         PDMEV_PUB_END_OFF:        rd_mux = {s_q.pub_end_en, 27'h0, s_q.pub_end_idx};
         PDMEV_IRQ_ENABLE_OFF:     rd_mux = {29'h0, s_q.irq_en};
         PDMEV_IRQ_ENABLE_SET_OFF: rd_mux = {29'h0, s_q.irq_en};
         PDMEV_BUSY_STATUS_OFF:    rd_mux = {30'h0, s_q.state};
         default:                  mapped = 1'b0;
      endcase
   end

   always_comb begin
      s_d             = s_q;
      s_d.start_pulse = 1'b0;
      s_d.stop_pulse  = 1'b0;
      s_d.ack         = setup_phase;
      s_d.err         = setup_phase && !mapped;
      s_d.rdata       = rd ? rd_mux : 32'h0000_0000;

      // software writes first, so a hardware set in the same cycle wins below
      if (wr) begin
         case (paddr)
            PDMEV_START_TRIGGER_OFF: s_d.start_pulse = pwdata[0];
            PDMEV_STOP_TRIGGER_OFF:  s_d.stop_pulse  = pwdata[0];
            PDMEV_STARTED_FLAG_OFF:  s_d.started_flag = pwdata[0];
            PDMEV_STOPPED_FLAG_OFF:  s_d.stopped_flag = pwdata[0];
            PDMEV_END_FLAG_OFF:      s_d.end_flag     = pwdata[0];
            PDMEV_PUB_STARTED_OFF: begin
               s_d.pub_started_idx = pwdata[PDMEV_CHANNEL_INDEX_W-1:0];
               s_d.pub_started_en  = pwdata[PDMEV_PUB_EN_BIT];
            end
            PDMEV_PUB_STOPPED_OFF: begin
               s_d.pub_stopped_idx = pwdata[PDMEV_CHANNEL_INDEX_W-1:0];
               s_d.pub_stopped_en  = pwdata[PDMEV_PUB_EN_BIT];
            end
            PDMEV_PUB_END_OFF: begin
               s_d.pub_end_idx = pwdata[PDMEV_CHANNEL_INDEX_W-1:0];
               s_d.pub_end_en  = pwdata[PDMEV_PUB_EN_BIT];
            end
            PDMEV_IRQ_ENABLE_OFF: begin
               s_d.irq_en[PDMEV_BIT_STARTED] = pwdata[PDMEV_BIT_STARTED];
               s_d.irq_en[PDMEV_BIT_STOPPED] = pwdata[PDMEV_BIT_STOPPED];
               s_d.irq_en[PDMEV_BIT_END]     = pwdata[PDMEV_BIT_END];
            end
            // ones set, zeros leave the enable alone
            PDMEV_IRQ_ENABLE_SET_OFF: s_d.irq_en = s_q.irq_en | pwdata[PDMEV_NUM_EVENTS-1:0];
            default: ;
         endcase
      end

      // transfer tracking; stop during a run waits for the core to drain
      case (s_q.state)
         PDMEV_IDLE:     if (s_q.start_pulse) s_d.state = PDMEV_RUNNING;
         PDMEV_RUNNING:  if (s_q.stop_pulse) s_d.state = PDMEV_DRAINING;
         PDMEV_DRAINING: if (core_stopped) s_d.state = PDMEV_IDLE;
         default:        s_d.state = PDMEV_IDLE;
      endcase
      if (core_stopped) begin
         s_d.state = PDMEV_IDLE;
      end

      if (core_started) begin
         s_d.started_flag = 1'b1;
      end
      if (core_stopped) begin
         s_d.stopped_flag = 1'b1;
      end
      // the core raises this for the count limit and for the last sample after a stop
      if (core_last_sample_stored) begin
         s_d.end_flag = 1'b1;
      end

      s_d.irq = (s_d.started_flag && s_d.irq_en[PDMEV_BIT_STARTED])
             || (s_d.stopped_flag && s_d.irq_en[PDMEV_BIT_STOPPED])
             || (s_d.end_flag && s_d.irq_en[PDMEV_BIT_END]);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q       <= '0;
         s_q.state <= PDMEV_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata     = s_q.rdata;
   assign pready     = s_q.ack;
   assign pslverr    = s_q.err;
   assign core_start = s_q.start_pulse;
   assign core_stop  = s_q.stop_pulse;
   assign irq        = s_q.irq;

   // event publishers
   pdmev_publish #(.NUM_CHANNELS(NUM_CHANNELS)) u_pub_started (
      .ref_clk       (ref_clk),
      .rst_n         (rst_n),
      .channel_index (s_q.pub_started_idx),
      .publish_en    (s_q.pub_started_en),
      .event_pulse   (core_started),
      .channel_q     (publish_started)
   );

   pdmev_publish #(.NUM_CHANNELS(NUM_CHANNELS)) u_pub_stopped (
      .ref_clk       (ref_clk),
      .rst_n         (rst_n),
      .channel_index (s_q.pub_stopped_idx),
      .publish_en    (s_q.pub_stopped_en),
      .event_pulse   (core_stopped),
      .channel_q     (stopped_publish_cfg)
   );

   pdmev_publish #(.NUM_CHANNELS(NUM_CHANNELS)) u_pub_end (
      .ref_clk       (ref_clk),
      .rst_n         (rst_n),
      .channel_index (s_q.pub_end_idx),
      .publish_en    (s_q.pub_end_en),
      .event_pulse   (core_last_sample_stored),
      .channel_q     (publish_end)
   );

   // apb timing
   chk_ready_after_setup: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (psel && !penable) |=> pready)
      else $error("pready missing after setup");

   chk_ready_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pready |=> !pready)
      else $error("pready held too long");

   chk_err_with_ready: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pslverr |-> pready)
      else $error("pslverr without pready");

   chk_rdata_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !pready |-> (prdata == 32'h0000_0000))
      else $error("read data outside the answer cycle");

   // event flags: a hardware set wins over a software clear in the same cycle
   chk_started_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
      core_started |=> s_q.started_flag)
      else $error("started flag missed");

   chk_started_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr && paddr == PDMEV_STARTED_FLAG_OFF && !pwdata[0] && !core_started) |=> !s_q.started_flag)
      else $error("started flag not cleared");

   chk_stopped_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
      core_stopped |=> s_q.stopped_flag)
      else $error("stopped flag missed");

   chk_stopped_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr && paddr == PDMEV_STOPPED_FLAG_OFF && !pwdata[0] && !core_stopped) |=> !s_q.stopped_flag)
      else $error("stopped flag not cleared");

   chk_end_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
      core_last_sample_stored |=> s_q.end_flag)
      else $error("end flag missed");

   chk_end_after_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (s_q.state == PDMEV_DRAINING && core_last_sample_stored) |=> s_q.end_flag)
      else $error("end after stop missed");

   chk_end_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr && paddr == PDMEV_END_FLAG_OFF && !pwdata[0] && !core_last_sample_stored) |=> !s_q.end_flag)
      else $error("end flag not cleared");

   // publishing follows the raw core pulse, gated by the configuration held at that edge
   chk_pub_cfg: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr && paddr == PDMEV_PUB_STARTED_OFF) |=> (s_q.pub_started_idx == $past(pwdata[3:0])))
      else $error("started publish cfg lost");

   chk_started_publish: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (core_started && s_q.pub_started_en && int'(s_q.pub_started_idx) < NUM_CHANNELS)
      |=> ($onehot(publish_started) && publish_started[$past(s_q.pub_started_idx)]))
      else $error("started event not published");

   chk_started_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !(core_started && s_q.pub_started_en) |=> (publish_started == '0))
      else $error("started channel pulsed without cause");

   chk_pub_stop_cfg: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr && paddr == PDMEV_PUB_STOPPED_OFF) |=> (s_q.pub_stopped_idx == $past(pwdata[3:0])))
      else $error("stopped publish cfg lost");

   chk_stopped_publish: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (core_stopped && s_q.pub_stopped_en && int'(s_q.pub_stopped_idx) < NUM_CHANNELS)
      |=> ($onehot(stopped_publish_cfg) && stopped_publish_cfg[$past(s_q.pub_stopped_idx)]))
      else $error("stopped event not published");

   chk_stopped_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !(core_stopped && s_q.pub_stopped_en) |=> (stopped_publish_cfg == '0))
      else $error("stopped channel pulsed without cause");

   chk_pub_end_cfg: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr && paddr == PDMEV_PUB_END_OFF)
      |=> ({s_q.pub_end_en, s_q.pub_end_idx} == {$past(pwdata[PDMEV_PUB_EN_BIT]), $past(pwdata[3:0])}))
      else $error("end publish cfg lost");

   chk_end_publish: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (core_last_sample_stored && s_q.pub_end_en && int'(s_q.pub_end_idx) < NUM_CHANNELS)
      |=> ($onehot(publish_end) && publish_end[$past(s_q.pub_end_idx)]))
      else $error("end event not published");

   chk_end_publish_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (core_last_sample_stored && !s_q.pub_end_en) |=> (publish_end == '0))
      else $error("end published while disabled");

   // interrupt enables and the level output
   chk_enable_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr && paddr == PDMEV_IRQ_ENABLE_OFF) |=> (s_q.irq_en == $past(pwdata[2:0])))
      else $error("enable write lost");

   chk_set_enables: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr && paddr == PDMEV_IRQ_ENABLE_SET_OFF) |=> ((s_q.irq_en & $past(pwdata[2:0])) == $past(pwdata[2:0])))
      else $error("set-enable did not set");

   chk_set_keeps_ones: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr && paddr == PDMEV_IRQ_ENABLE_SET_OFF) |=> ((s_q.irq_en & $past(s_q.irq_en)) == $past(s_q.irq_en)))
      else $error("set-enable cleared a bit");

   chk_enable_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (rd && paddr == PDMEV_IRQ_ENABLE_SET_OFF) |=> (prdata == {29'h0, $past(s_q.irq_en)}))
      else $error("set-enable read wrong");

   // irq is registered with the flags, so it must always match the stored flags and enables
   chk_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
      irq == ((s_q.started_flag && s_q.irq_en[PDMEV_BIT_STARTED])
              || (s_q.stopped_flag && s_q.irq_en[PDMEV_BIT_STOPPED])
              || (s_q.end_flag && s_q.irq_en[PDMEV_BIT_END])))
      else $error("irq level wrong");

   // triggers and transfer tracking
   chk_start_trigger: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr && paddr == PDMEV_START_TRIGGER_OFF && pwdata[0]) |=> core_start ##1 !core_start)
      else $error("start trigger pulse wrong");

   chk_stop_trigger: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr && paddr == PDMEV_STOP_TRIGGER_OFF && pwdata[0]) |=> core_stop ##1 !core_stop)
      else $error("stop trigger pulse wrong");

   chk_run_on_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (s_q.state == PDMEV_IDLE && core_start && !core_stopped) |=> (s_q.state == PDMEV_RUNNING))
      else $error("start did not enter running");

   chk_drain_on_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (s_q.state == PDMEV_RUNNING && core_stop && !core_stopped) |=> (s_q.state == PDMEV_DRAINING))
      else $error("stop did not enter draining");
endmodule
`default_nettype wire

// *** common/pdmev_pkg.sv ***
// package: register map, field layout and reset values of the pdm event/interrupt block
`default_nettype none
package pdmev_pkg;
   localparam logic [11:0] PDMEV_START_TRIGGER_OFF = 12'h000;
   localparam logic [11:0] PDMEV_STOP_TRIGGER_OFF  = 12'h004;
   localparam logic [11:0] PDMEV_STARTED_FLAG_OFF  = 12'h100;
   localparam logic [11:0] PDMEV_STOPPED_FLAG_OFF  = 12'h104;
   localparam logic [11:0] PDMEV_END_FLAG_OFF      = 12'h108;
   localparam logic [11:0] PDMEV_PUB_STARTED_OFF   = 12'h180;
   localparam logic [11:0] PDMEV_PUB_STOPPED_OFF   = 12'h184;
   localparam logic [11:0] PDMEV_PUB_END_OFF       = 12'h188;
   localparam logic [11:0] PDMEV_IRQ_ENABLE_OFF    = 12'h300;
   localparam logic [11:0] PDMEV_IRQ_ENABLE_SET_OFF = 12'h304;
   localparam logic [11:0] PDMEV_BUSY_STATUS_OFF   = 12'h400;
   // event bit positions in the enable registers
   localparam int PDMEV_BIT_STARTED = 0;
   localparam int PDMEV_BIT_STOPPED = 1;
   localparam int PDMEV_BIT_END     = 2;
   localparam int PDMEV_NUM_EVENTS  = 3;
   // publish register layout
   localparam int PDMEV_PUB_EN_BIT  = 31;
   localparam int PDMEV_CHANNEL_INDEX_W     = 4;
   localparam logic [31:0] PDMEV_RESET_VALUE = 32'h0000_0000;
   typedef enum logic [1:0] {
      PDMEV_IDLE     = 2'b00,
      PDMEV_RUNNING  = 2'b01,
      PDMEV_DRAINING = 2'b11
   } pdmev_state_t;
endpackage
`default_nettype wire

// *** hdl/pdmev_publish.sv ***
// one event publisher: broadcasts a pulse onto the chosen interconnect channel when enabled
`timescale 1ns/100ps
`default_nettype none
module pdmev_publish
   import pdmev_pkg::*;
#(
   parameter int NUM_CHANNELS = 16
) (
   // clock and reset
   input  wire logic                    ref_clk,
   input  wire logic                    rst_n,
   // configuration and event
   input  wire logic [PDMEV_CHANNEL_INDEX_W-1:0] channel_index,
   input  wire logic                    publish_en,
   input  wire logic                    event_pulse,
   // interconnect
   output logic [NUM_CHANNELS-1:0]      channel_q
);
   initial begin
      if (NUM_CHANNELS < 1 || NUM_CHANNELS > (1 << PDMEV_CHANNEL_INDEX_W)) begin
         $error("pdmev_publish: NUM_CHANNELS out of range");
      end
   end

   typedef struct packed {
      logic [NUM_CHANNELS-1:0] chan;
   } pdmev_pub_t;

   pdmev_pub_t s_q;
   pdmev_pub_t s_d;

   always_comb begin
      s_d = '0;
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         // a disabled publisher stays silent on every channel
         s_d.chan[i] = event_pulse && publish_en && (int'(channel_index) == i);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign channel_q = s_q.chan;
endmodule
`default_nettype wire

// *** verification/pdmev_core_model.sv ***
// behavioural sampling and dma core that answers the start and stop triggers with event pulses
`timescale 1ns/100ps
`default_nettype none
module pdmev_core_model #(
   parameter int MAX_COUNT = 40,
   parameter int STOP_LAT  = 3
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // triggers from the register block
   input  wire logic core_start,
   input  wire logic core_stop,
   // event pulses back to the register block
   output logic      core_started,
   output logic      core_last_sample_stored,
   output logic      core_stopped
);
   logic run_q;
   logic fin_q;
   int   cnt_q;
   int   stop_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         {run_q, fin_q, core_started, core_last_sample_stored, core_stopped} <= 5'h00;
         cnt_q  <= 0;
         stop_q <= 0;
      end else begin
         core_started            <= 1'b0;
         core_last_sample_stored <= 1'b0;
         core_stopped            <= fin_q;
         fin_q                   <= 1'b0;
         if (core_start && !run_q) begin
            run_q        <= 1'b1;
            cnt_q        <= 0;
            core_started <= 1'b1;
         end else if (run_q && stop_q == 0 && core_stop) begin
            stop_q <= STOP_LAT;
         end else if (stop_q > 1) begin
            stop_q <= stop_q - 1;
         end else if (stop_q == 1) begin
            // samples taken after the stop drain first, then the transfer finishes
            core_last_sample_stored <= 1'b1;
            fin_q                   <= 1'b1;
            stop_q                  <= 0;
            run_q                   <= 1'b0;
         end else if (run_q) begin
            if (cnt_q == MAX_COUNT - 1) begin
               core_last_sample_stored <= 1'b1;
               cnt_q                   <= 0;
            end else begin
               cnt_q <= cnt_q + 1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** verification/test_pdm_event_interrupt_regs.sv ***
// register-level testbench of the pdm event and interrupt block over apb
`timescale 1ns/100ps
`default_nettype none
module test_pdm_event_interrupt_regs;
   import pdmev_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst_n   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        core_start, core_stop, core_started, core_last_sample_stored, core_stopped;
   logic [15:0] publish_started, stopped_publish_cfg, publish_end;
   logic [15:0] seen_started = 16'h0000;
   logic [15:0] seen_stopped = 16'h0000;
   logic [15:0] seen_end     = 16'h0000;
   logic        irq;
   logic        last_err;
   logic [31:0] rd;
   int          err_total = 0;
   int          tests_run = 0;

   pdmev_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .core_start(core_start), .core_stop(core_stop), .core_started(core_started),
      .core_last_sample_stored(core_last_sample_stored), .core_stopped(core_stopped),
      .publish_started(publish_started), .stopped_publish_cfg(stopped_publish_cfg),
      .publish_end(publish_end), .irq(irq));
   pdmev_core_model core (.ref_clk(ref_clk), .rst_n(rst_n), .core_start(core_start),
      .core_stop(core_stop), .core_started(core_started),
      .core_last_sample_stored(core_last_sample_stored), .core_stopped(core_stopped));

   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end
   // publish pulses last one cycle, so collect every channel that ever fired
   always @(posedge ref_clk) begin
      seen_started <= seen_started | publish_started;
      seen_stopped <= seen_stopped | stopped_publish_cfg;
      seen_end     <= seen_end | publish_end;
   end

   task automatic close_out();
      if (err_total == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         check("apb timeout", 32'h1, 32'h0);
         close_out();
      end
      rd       = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check($sformatf("reg %h", a), rd, exp);
   endtask
   // irq follows a write at the access edge, so look once it has settled
   task automatic chk_irq(input logic exp);
      @(negedge ref_clk);
      check("irq", {31'h0, irq}, {31'h0, exp});
   endtask
   // which: 0 started, 1 last sample stored, 2 stopped
   task automatic wait_ev(input int which);
      int n;
      for (n = 0; n < 200; n++) begin
         @(posedge ref_clk);
         if ((which == 0 && core_started === 1'b1) || (which == 1 && core_last_sample_stored === 1'b1)
             || (which == 2 && core_stopped === 1'b1)) break;
      end
      if (n >= 200) begin
         check("event timeout", 32'h1, 32'h0);
         close_out();
      end
      repeat (2) @(posedge ref_clk);
   endtask

   initial begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd_chk(PDMEV_STARTED_FLAG_OFF, 32'h0000_0000);
      rd_chk(PDMEV_STOPPED_FLAG_OFF, 32'h0000_0000);
      rd_chk(PDMEV_END_FLAG_OFF, 32'h0000_0000);
      rd_chk(PDMEV_PUB_END_OFF, 32'h0000_0000);
      rd_chk(PDMEV_IRQ_ENABLE_OFF, 32'h0000_0000);
      apb(1'b1, PDMEV_PUB_STARTED_OFF, 32'h8000_0003);
      apb(1'b1, PDMEV_PUB_STOPPED_OFF, 32'h8000_0005);
      apb(1'b1, PDMEV_PUB_END_OFF, 32'h0000_0007);
      rd_chk(PDMEV_PUB_STARTED_OFF, 32'h8000_0003);
      rd_chk(PDMEV_PUB_STOPPED_OFF, 32'h8000_0005);
      rd_chk(PDMEV_PUB_END_OFF, 32'h0000_0007);
      apb(1'b1, PDMEV_IRQ_ENABLE_OFF, 32'h0000_0001);
      rd_chk(PDMEV_IRQ_ENABLE_SET_OFF, 32'h0000_0001);
      apb(1'b1, PDMEV_IRQ_ENABLE_SET_OFF, 32'h0000_0004);
      rd_chk(PDMEV_IRQ_ENABLE_OFF, 32'h0000_0005);
      apb(1'b1, PDMEV_IRQ_ENABLE_SET_OFF, 32'h0000_0000);
      rd_chk(PDMEV_IRQ_ENABLE_SET_OFF, 32'h0000_0005);
      // start: flag, publish on channel 3, irq through the started enable
      apb(1'b1, PDMEV_START_TRIGGER_OFF, 32'h0000_0001);
      wait_ev(0);
      rd_chk(PDMEV_STARTED_FLAG_OFF, 32'h0000_0001);
      check("seen_started", {16'h0000, seen_started}, 32'h0000_0008);
      chk_irq(1'b1);
      apb(1'b1, PDMEV_STARTED_FLAG_OFF, 32'h0000_0000);
      chk_irq(1'b0);
      // end by sample count while end publishing is disabled
      wait_ev(1);
      rd_chk(PDMEV_END_FLAG_OFF, 32'h0000_0001);
      chk_irq(1'b1);
      check("seen_end", {16'h0000, seen_end}, 32'h0000_0000);
      apb(1'b1, PDMEV_END_FLAG_OFF, 32'h0000_0000);
      chk_irq(1'b0);
      apb(1'b1, PDMEV_PUB_END_OFF, 32'h8000_0007);
      // stop mid-transfer: end then stopped
      apb(1'b1, PDMEV_STOP_TRIGGER_OFF, 32'h0000_0001);
      wait_ev(2);
      rd_chk(PDMEV_STOPPED_FLAG_OFF, 32'h0000_0001);
      rd_chk(PDMEV_END_FLAG_OFF, 32'h0000_0001);
      check("seen_stopped", {16'h0000, seen_stopped}, 32'h0000_0020);
      check("seen_end", {16'h0000, seen_end}, 32'h0000_0080);
      chk_irq(1'b1);
      apb(1'b1, PDMEV_IRQ_ENABLE_OFF, 32'h0000_0000);
      chk_irq(1'b0);
      apb(1'b1, PDMEV_IRQ_ENABLE_OFF, 32'h0000_0002);
      chk_irq(1'b1);
      apb(1'b1, PDMEV_STOPPED_FLAG_OFF, 32'h0000_0000);
      chk_irq(1'b0);
      rd_chk(PDMEV_STOPPED_FLAG_OFF, 32'h0000_0000);
      // unmapped address is refused
      rd_chk(12'h200, 32'h0000_0000);
      check("pslverr", {31'h0, last_err}, 32'h1);
      close_out();
   end
endmodule
`default_nettype wire
